//--- bench/cts_unit_model.sv
// Behavioural control unit facing the channel tag sequencer.
// Assumes tags are sampled on rising clk and answered one edge later.
`timescale 1ns/1ps
module cts_unit_model
   import cts_pkg::*;
#(
   parameter logic [7:0] DEV = 8'h5A
)
(
   // Outbound lines from the channel.
   input  wire logic [7:0] bus_out,
   input  wire logic       bus_out_par,
   input  wire logic       clk,
   input  wire logic       addr_o,
   input  wire logic       cmd_o,
   input  wire logic       ack_o,
   input  wire logic       grant_o,
   input  wire logic       opn_o,
   // Bench controls and the captured outbound byte.
   input  wire logic       sbusy,
   input  wire logic       want,
   output logic [7:0]      got,
   // Inbound lines to the channel.
   output logic [7:0]      bus_in,
   output logic            bus_in_par,
   output logic            conn,
   output logic            addr_i,
   output logic            stat_i,
   output logic            req_i,
   output logic            attn_i,
   output logic            gret
);
   // ==========
   // Inbound bus.
   logic [7:0] v, c;
   logic [7:0] cnt = 8'h00;
   logic       drv;
   int         k;
   // A released bus shows a moving pattern, so stale data cannot match.
   assign bus_in = drv ? v : cnt;
   assign bus_in_par = ~^bus_in;
   always @(posedge clk) cnt <= cnt + 8'h01;
   // Every wait gives up after 200 edges, so a stalled channel cannot hang the unit.
`define UW(x) begin k = 0; do begin @(posedge clk); k++; end while (!(x) && k < 200); end
   // Unit sequence; each step waits for its cause at a clock edge.
   initial
   begin
      {v, c, got, drv, conn, addr_i, stat_i, req_i, attn_i, gret} = '0;
      forever
      begin
         @(posedge clk);
         if (opn_o && grant_o && !addr_o && attn_i)
         begin
            {v, drv, addr_i, conn, attn_i, gret} <= {DEV, 5'h1C};
            `UW(cmd_o) addr_i <= 1'b0;
            `UW(!cmd_o) {conn, drv} <= 2'b00;
         end
         else if (opn_o && grant_o && addr_o && bus_out == DEV && ^{bus_out, bus_out_par})
         begin
            if (sbusy)
            begin
               {v, drv, stat_i, gret} <= {8'h50, 3'b110};
               `UW(!grant_o) {stat_i, drv} <= 2'b00;
            end
            else
            begin
               {conn, gret} <= 2'b10;
               `UW(!addr_o) {v, drv, addr_i} <= {DEV, 2'b11};
               `UW(cmd_o) {c, addr_i} <= {bus_out, 1'b0};
               `UW(!cmd_o) {v, stat_i} <= {8'h08, 1'b1};
               `UW(ack_o || cmd_o) stat_i <= 1'b0;
               `UW(!ack_o && !cmd_o) {v, drv, req_i} <= {8'hC3, !c[0], 1'b1};
               `UW(ack_o) {req_i, got} <= {1'b0, bus_out};
               `UW(!ack_o) {conn, drv} <= 2'b00;
            end
         end
         else
         begin
            // An idle unit latches attention and passes an unclaimed grant on.
            {attn_i, gret} <= {attn_i | want, grant_o};
         end
      end
   end
endmodule

//--- bench/tb_top.sv
// Self-checking bench: sequencer against the behavioural unit.
// Assumes the unit answers at device address 5A.
`timescale 1ns/1ps
module tb_top
   import cts_pkg::*;
;
   // ==========
   // Signals.
   logic        CLK = 1'b0, RST = 1'b1, wr = 1'b0, rq = 1'b0, sb = 1'b0, at = 1'b0;
   logic [7:0]  ad = '0, bi, bo, got;
   logic [31:0] wd = '0, rd, r;
   logic        bp, bip, ao, co, ko, go, oe, ci, ai, si, ri, ti, gh, so, gr;
   int          fails = 0, n_checks = 0;
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin fails++; \
   $display("Error %0t: got %h want %h", $time, a, e); end end
   always #4 CLK = ~CLK;
   cts_channel #(.WDOG_CYC(64)) dut (.CLK(CLK), .RST(RST), .REG_ADDR(ad), .REG_WDATA(wd),
      .REG_WR(wr), .REG_RD(rq), .REG_RDATA(rd), .BUS_OUT(bo), .BUS_OUT_PAR(bp),
      .CHAN_ADDR_STROBE(ao), .CHAN_CMD_STROBE(co), .CHAN_DATA_ACK(ko), .CHAIN_GRANT(go),
      .GRANT_HOLD(gh), .CHAN_OP_ENABLE(oe), .SUPPRESS_OUT(so), .BUS_IN(bi), .BUS_IN_PAR(bip),
      .UNIT_CONNECTED(ci), .UNIT_ADDR_STROBE(ai), .UNIT_STATUS_STROBE(si),
      .UNIT_DATA_REQUEST(ri), .UNIT_ATTN_REQUEST(ti), .GRANT_RETURN(gr));
   cts_unit_model unit (.bus_out(bo), .bus_out_par(bp), .clk(CLK), .addr_o(ao), .cmd_o(co),
      .ack_o(ko), .grant_o(go), .opn_o(oe), .sbusy(sb), .want(at), .got(got), .bus_in(bi),
      .bus_in_par(bip), .conn(ci), .addr_i(ai), .stat_i(si), .req_i(ri), .attn_i(ti),
      .gret(gr));
   // Hold follows the grant; looked at on the falling edge, where both have settled.
   always @(negedge CLK)
      if (!RST && gh !== go)
         `CHK(gh, go)
   // Closing report, also reached when a wait runs out.
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic wrr(input logic [7:0] a, input logic [31:0] d);
      @(posedge CLK) {ad, wd, wr} <= {a, d, 1'b1};
      @(posedge CLK) wr <= 1'b0;
   endtask
   task automatic rdr(input logic [7:0] a);
      @(posedge CLK) {ad, rq} <= {a, 1'b1};
      @(posedge CLK) rq <= 1'b0;
      #1 r = rd;
   endtask
   // Poll until the sequencer is idle; the bound stops a hang.
   task automatic idle();
      repeat (4) @(posedge CLK);
      for (int i = 0; i < 300; i++)
      begin
         rdr(CTS_OFF_STATUS);
         if (r[8] === 1'b0)
            return;
      end
      fails++;
      stop_test();
   endtask
   task automatic sel(input logic [7:0] dev, input logic [7:0] cmd, input logic [31:0] ctl);
      wrr(CTS_OFF_STATUS, 32'h3F);
      wrr(CTS_OFF_CTRL, ctl);
      wrr(CTS_OFF_DEVADR, {24'h0, dev});
      wrr(CTS_OFF_CMD, {24'h0, cmd});
      wrr(CTS_OFF_TXDATA, 32'hA5);
      wrr(CTS_OFF_START, 32'h1);
      idle();
   endtask
   // Reset values, unmapped read, suppress alone while the port is disabled.
   task automatic t_reset();
      `CHK({oe, go, gh, ao, co, ko, so, bp, bo}, 16'h0100)
      rdr(CTS_OFF_CTRL);
      `CHK(r, 32'h0)
      rdr(8'hFC);
      `CHK(r, 32'h0)
      wrr(CTS_OFF_CTRL, 32'h2);
      rdr(CTS_OFF_CTRL);
      `CHK({r[5:0], oe, so, go}, 9'h012)
      $display("reset test done");
   endtask
   task automatic t_out();
      sel(8'h5A, 8'h01, 32'h15);
      `CHK(got, 8'hA5)
      `CHK(r[23:16], 8'h08)
      `CHK(r[0], 1'b1)
      $display("outbound selection done");
   endtask
   task automatic t_in();
      sel(8'h5A, 8'h02, 32'h11);
      `CHK(r[11], 1'b1)
      rdr(CTS_OFF_RXDATA);
      `CHK(r[7:0], 8'hC3)
      $display("inbound selection done");
   endtask
   // Probe command refused with the command strobe; the unit still sends its byte.
   task automatic t_refuse();
      sel(8'h5A, 8'h00, 32'h19);
      `CHK(r[0], 1'b0)
      rdr(CTS_OFF_RXDATA);
      `CHK(r[7:0], 8'hC3)
      $display("refused selection done");
   endtask
   task automatic t_sbusy();
      sb <= 1'b1;
      sel(8'h5A, 8'h02, 32'h11);
      sb <= 1'b0;
      `CHK(r[2:1], 2'b01)
      `CHK(r[23:16], 8'h50)
      $display("short busy done");
   endtask
   // No unit claims the address, so the grant comes back.
   task automatic t_nounit();
      sel(8'h33, 8'h01, 32'h11);
      `CHK(r[4:0], 5'h10)
      $display("no unit done");
   endtask
   task automatic t_resel();
      at <= 1'b1;
      wrr(CTS_OFF_STATUS, 32'h3F);
      at <= 1'b0;
      wrr(CTS_OFF_CTRL, 32'h31);
      idle();
      `CHK(r[5], 1'b1)
      `CHK(r[31:24], 8'h5A)
      $display("reselection done");
   endtask
   // Main sequence.
   initial
   begin
      repeat (12) @(posedge CLK);
      RST <= 1'b0;
      t_reset();
      t_out();
      t_in();
      t_refuse();
      t_sbusy();
      t_nounit();
      t_resel();
      stop_test();
   end
endmodule

//--- logic/cts_channel.sv
// Channel-side tag sequencer: selection, short busy, reselection, bytes.
// Assumes inbound tags are synchronous to CLK; software uses strobes.
`timescale 1ns/1ps
module cts_channel
   import cts_pkg::*;
#(
   parameter int WDOG_CYC = CTS_WDOG_CYC
)
(
   // Clock and reset.
   input  wire logic        CLK,
   input  wire logic        RST,
   // Software register port.
   input  wire logic [7:0]  REG_ADDR,
   input  wire logic [31:0] REG_WDATA,
   input  wire logic        REG_WR,
   input  wire logic        REG_RD,
   output logic [31:0]      REG_RDATA,
   // Outbound byte lines and tags.
   output logic [7:0]       BUS_OUT,
   output logic             BUS_OUT_PAR,
   output logic             CHAN_ADDR_STROBE,
   output logic             CHAN_CMD_STROBE,
   output logic             CHAN_DATA_ACK,
   output logic             CHAIN_GRANT,
   output logic             GRANT_HOLD,
   output logic             CHAN_OP_ENABLE,
   output logic             SUPPRESS_OUT,
   // Inbound byte lines and tags.
   input  wire logic [7:0]  BUS_IN,
   input  wire logic        BUS_IN_PAR,
   input  wire logic        UNIT_CONNECTED,
   input  wire logic        UNIT_ADDR_STROBE,
   input  wire logic        UNIT_STATUS_STROBE,
   input  wire logic        UNIT_DATA_REQUEST,
   input  wire logic        UNIT_ATTN_REQUEST,
   input  wire logic        GRANT_RETURN
);

   // ======================================================
   // Register file state.
   logic [CTS_CTL_W-1:0] ctl_q, ctl_d;
   logic [7:0]           dev_q, dev_d;
   logic [7:0]           cmdb_q, cmdb_d;
   logic [31:0]          rdat_q, rdat_d;

   // Sequencer state.
   cts_state_t           st_q, st_d;
   logic                 addr_q, addr_d;
   logic                 cmd_q, cmd_d;
   logic                 ack_q, ack_d;
   logic                 sel_q, sel_d;
   logic [7:0]           bus_q, bus_d;
   logic                 par_q;
   logic [7:0]           sbyte_q, sbyte_d;
   logic [7:0]           rsa_q, rsa_d;
   logic [7:0]           rx_q, rx_d;
   logic                 rxv_q, rxv_d;
   logic [7:0]           txb_q, txb_d;
   logic                 txv_q, txv_d;
   logic                 go_q, go_d;
   logic [CTS_FL_W-1:0]  fl_q, fl_d, fl_set;

   // Decoded strobes and helpers.
   logic                 wr_start, wr_tx, rd_rx;
   logic [CTS_FL_W-1:0]  fl_clr;
   logic                 op_en, in_ok, par_gen, tmo, wd_run;
   logic                 acc_now, sb_ok;

   // ======================================================
   // Parity on both byte lanes; outbound parity follows the next byte.
   cts_parity #(.W(8)) u_par_out (
      .data    (bus_d),
      .par_in  (1'b0),
      .par_gen (par_gen),
      .par_ok  ()
   );

   cts_parity #(.W(8)) u_par_in (
      .data    (BUS_IN),
      .par_in  (BUS_IN_PAR),
      .par_gen (),
      .par_ok  (in_ok)
   );

   // Watchdog: any tag wait other than the idle or connected rest.
   assign wd_run = (st_q != ST_IDLE) && (st_q != ST_CONN);

   cts_wdog #(.LIMIT(WDOG_CYC)) u_wdog (
      .clk     (CLK),
      .rst     (RST),
      .run     (wd_run),
      .kick    (st_d != st_q),
      .expired (tmo)
   );

   // ======================================================
   // Register writes and one-cycle-late read data.
   always_comb
   begin
      ctl_d    = ctl_q;
      dev_d    = dev_q;
      cmdb_d   = cmdb_q;
      wr_start = 1'b0;
      wr_tx    = 1'b0;
      fl_clr   = '0;
      rd_rx    = REG_RD && (REG_ADDR == CTS_OFF_RXDATA);
      if (REG_WR)
      begin
         case (REG_ADDR)
            CTS_OFF_CTRL:   ctl_d    = REG_WDATA[CTS_CTL_W-1:0];
            CTS_OFF_DEVADR: dev_d    = REG_WDATA[7:0];
            CTS_OFF_CMD:    cmdb_d   = REG_WDATA[7:0];
            CTS_OFF_START:  wr_start = REG_WDATA[0];
            CTS_OFF_STATUS: fl_clr   = REG_WDATA[CTS_FL_W-1:0];
            CTS_OFF_TXDATA: wr_tx    = 1'b1;
            default:        ctl_d    = ctl_q;
         endcase
      end
      rdat_d = 32'h0000_0000;
      if (REG_RD)
      begin
         case (REG_ADDR)
            CTS_OFF_CTRL:   rdat_d = {26'h0, ctl_q};
            CTS_OFF_DEVADR: rdat_d = {24'h00_0000, dev_q};
            CTS_OFF_CMD:    rdat_d = {24'h00_0000, cmdb_q};
            CTS_OFF_STATUS: rdat_d = {rsa_q, sbyte_q, 4'h0, rxv_q, txv_q,
                                      (st_q == ST_CONN || st_q == ST_DXACK),
                                      (st_q != ST_IDLE), 2'h0, fl_q};
            CTS_OFF_TXDATA: rdat_d = {24'h00_0000, txb_q};
            CTS_OFF_RXDATA: rdat_d = {24'h00_0000, rx_q};
            default:        rdat_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         ctl_q  <= CTS_CTL_RST;
         dev_q  <= 8'h00;
         cmdb_q <= 8'h00;
         rdat_q <= 32'h0000_0000;
      end
      else
      begin
         ctl_q  <= ctl_d;
         dev_q  <= dev_d;
         cmdb_q <= cmdb_d;
         rdat_q <= rdat_d;
      end
   end

   // ======================================================
   // Status classification of the byte on the inbound lane.
   always_comb
   begin
      acc_now = (BUS_IN[CTS_SB_QUAL] && BUS_IN[CTS_SB_ECHK]) ||
                ((cmdb_q != CTS_PROBE_CMD) && (BUS_IN == 8'h00)) ||
                ((cmdb_q != CTS_PROBE_CMD) && BUS_IN[CTS_SB_PDONE] &&
                 !BUS_IN[CTS_SB_ALERT] && !BUS_IN[CTS_SB_CFREE] &&
                 !BUS_IN[CTS_SB_BUSY] && !BUS_IN[CTS_SB_ECHK] &&
                 !BUS_IN[CTS_SB_EXC]);
      sb_ok = (BUS_IN == 8'h50) || (BUS_IN == 8'h70) || (BUS_IN == 8'h10);
   end

   assign op_en = ctl_q[CTS_CTL_OPEN];

   // ======================================================
   // Tag sequencer. Each step waits on one inbound tag edge; the
   // watchdog frees the port if a unit never answers.
   always_comb
   begin
      st_d    = st_q;
      addr_d  = addr_q;
      cmd_d   = cmd_q;
      ack_d   = ack_q;
      sel_d   = sel_q;
      bus_d   = bus_q;
      sbyte_d = sbyte_q;
      rsa_d   = rsa_q;
      rx_d    = rx_q;
      rxv_d   = rxv_q && !rd_rx;
      txb_d   = wr_tx ? REG_WDATA[7:0] : txb_q;
      txv_d   = txv_q || wr_tx;
      go_d    = go_q || wr_start;
      fl_set  = '0;
      case (st_q)
         ST_IDLE:
         begin
            if (op_en && go_q && !UNIT_CONNECTED && !GRANT_RETURN)
            begin
               bus_d  = dev_q;
               addr_d = 1'b1;
               go_d   = 1'b0;
               st_d   = ST_SADDR;
            end
            else if (op_en && ctl_q[CTS_CTL_POLL] && UNIT_ATTN_REQUEST &&
                     !UNIT_CONNECTED && !GRANT_RETURN)
            begin
               sel_d = 1'b1;
               st_d  = ST_POLL;
            end
         end
         ST_SADDR:
         begin
            // Address has stood one cycle before the grant rises.
            if (!UNIT_CONNECTED && !GRANT_RETURN)
            begin
               sel_d = 1'b1;
               st_d  = ST_SWAIT;
            end
         end
         ST_SWAIT:
         begin
            if (UNIT_CONNECTED)
            begin
               addr_d = 1'b0;
               st_d   = ST_SADRIN;
            end
            else if (UNIT_STATUS_STROBE)
            begin
               sbyte_d              = BUS_IN;
               fl_set[CTS_FL_SBSY]  = 1'b1;
               fl_set[CTS_FL_ERR]   = !sb_ok || !in_ok;
               sel_d                = 1'b0;
               st_d                 = ST_SBWAIT;
            end
            else if (GRANT_RETURN)
            begin
               sel_d               = 1'b0;
               addr_d              = 1'b0;
               fl_set[CTS_FL_NOU]  = 1'b1;
               st_d                = ST_IDLE;
            end
         end
         ST_SBWAIT:
         begin
            if (!UNIT_STATUS_STROBE)
            begin
               addr_d = 1'b0;
               st_d   = ST_IDLE;
            end
         end
         ST_SADRIN:
         begin
            if (UNIT_ADDR_STROBE)
            begin
               fl_set[CTS_FL_ERR] = (BUS_IN != dev_q) || !in_ok;
               bus_d              = cmdb_q;
               cmd_d              = 1'b1;
               st_d               = ST_SCMD;
            end
         end
         ST_SCMD:
         begin
            if (!UNIT_ADDR_STROBE)
            begin
               cmd_d = 1'b0;
               st_d  = ST_SCMDDN;
            end
         end
         ST_SCMDDN:
         begin
            if (UNIT_STATUS_STROBE)
            begin
               sbyte_d            = BUS_IN;
               fl_set[CTS_FL_ACC] = acc_now;
               fl_set[CTS_FL_ERR] = !in_ok;
               cmd_d              = ctl_q[CTS_CTL_REFU];
               ack_d              = !ctl_q[CTS_CTL_REFU];
               st_d               = ST_SSTAT;
            end
         end
         ST_SSTAT:
         begin
            if (!UNIT_STATUS_STROBE)
            begin
               cmd_d = 1'b0;
               ack_d = 1'b0;
               sel_d = sel_q && UNIT_CONNECTED;
               st_d  = UNIT_CONNECTED ? ST_CONN : ST_IDLE;
            end
         end
         ST_CONN:
         begin
            if (!UNIT_CONNECTED)
            begin
               sel_d = 1'b0;
               st_d  = ST_IDLE;
            end
            else if (UNIT_STATUS_STROBE)
            begin
               sbyte_d = BUS_IN;
               ack_d   = 1'b1;
               st_d    = ST_SSTAT;
            end
            else if (UNIT_DATA_REQUEST && ctl_q[CTS_CTL_DOUT] && txv_q)
            begin
               bus_d = txb_q;
               txv_d = wr_tx;
               ack_d = 1'b1;
               st_d  = ST_DXACK;
            end
            else if (UNIT_DATA_REQUEST && !ctl_q[CTS_CTL_DOUT] && !rxv_q)
            begin
               rx_d               = BUS_IN;
               rxv_d              = 1'b1;
               fl_set[CTS_FL_ERR] = !in_ok;
               ack_d              = 1'b1;
               st_d               = ST_DXACK;
            end
            else if (!ctl_q[CTS_CTL_HOLD])
            begin
               sel_d = 1'b0;
               st_d  = ST_DISC;
            end
         end
         ST_DXACK:
         begin
            // The outbound byte stays put until the request falls.
            if (!UNIT_DATA_REQUEST)
            begin
               ack_d = 1'b0;
               st_d  = ST_CONN;
            end
         end
         ST_DISC:
         begin
            if (!UNIT_CONNECTED)
               st_d = ST_IDLE;
         end
         ST_POLL:
         begin
            if (UNIT_ADDR_STROBE && UNIT_CONNECTED)
            begin
               rsa_d               = BUS_IN;
               fl_set[CTS_FL_RSEL] = 1'b1;
               fl_set[CTS_FL_ERR]  = !in_ok;
               cmd_d               = 1'b1;
               st_d                = ST_RSCMD;
            end
            else if (GRANT_RETURN)
            begin
               sel_d = 1'b0;
               st_d  = ST_IDLE;
            end
         end
         ST_RSCMD:
         begin
            if (!UNIT_ADDR_STROBE)
            begin
               cmd_d = 1'b0;
               st_d  = ST_CONN;
            end
         end
         default:
            st_d = ST_IDLE;
      endcase
      // A stuck wait or a disable drops the address, command, ack and grant tags at once.
      if (tmo || !op_en)
      begin
         fl_set[CTS_FL_TMO] = tmo;
         addr_d = 1'b0;
         cmd_d  = 1'b0;
         ack_d  = 1'b0;
         sel_d  = 1'b0;
         st_d   = ST_IDLE;
      end
      // Hardware set wins over a software clear in the same cycle.
      fl_d = (fl_q & ~fl_clr) | fl_set;
   end

   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         st_q    <= ST_IDLE;
         addr_q  <= 1'b0;
         cmd_q   <= 1'b0;
         ack_q   <= 1'b0;
         sel_q   <= 1'b0;
         bus_q   <= 8'h00;
         par_q   <= 1'b1;
         sbyte_q <= 8'h00;
         rsa_q   <= 8'h00;
         rx_q    <= 8'h00;
         rxv_q   <= 1'b0;
         txb_q   <= 8'h00;
         txv_q   <= 1'b0;
         go_q    <= 1'b0;
         fl_q    <= '0;
      end
      else
      begin
         st_q    <= st_d;
         addr_q  <= addr_d;
         cmd_q   <= cmd_d;
         ack_q   <= ack_d;
         sel_q   <= sel_d;
         bus_q   <= bus_d;
         par_q   <= par_gen;
         sbyte_q <= sbyte_d;
         rsa_q   <= rsa_d;
         rx_q    <= rx_d;
         rxv_q   <= rxv_d;
         txb_q   <= txb_d;
         txv_q   <= txv_d;
         go_q    <= go_d;
         fl_q    <= fl_d;
      end
   end

   // ======================================================
   // Outputs straight from flip-flops.
   assign REG_RDATA        = rdat_q;
   assign BUS_OUT          = bus_q;
   assign BUS_OUT_PAR      = par_q;
   assign CHAN_ADDR_STROBE = addr_q;
   assign CHAN_CMD_STROBE  = cmd_q;
   assign CHAN_DATA_ACK    = ack_q;
   assign CHAIN_GRANT      = sel_q;
   assign GRANT_HOLD       = sel_q;
   assign CHAN_OP_ENABLE   = ctl_q[CTS_CTL_OPEN];
   assign SUPPRESS_OUT     = ctl_q[CTS_CTL_SUPP];

   // ======================================================
   // Checks on the tags this end drives.
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);

   sequence s_resel_go;
      cmd_q [*1] ##1 (cmd_q || !UNIT_ADDR_STROBE);
   endsequence

   grant_rise_ok_a: assert property ($rose(sel_q) |->
      !$past(UNIT_CONNECTED) && !$past(GRANT_RETURN))
      else $error("chain grant rose while unit connected or grant returned");
   addr_before_grant_a: assert property (
      $rose(sel_q) && addr_q |-> $past(addr_q) && bus_q == dev_q)
      else $error("chain grant rose without standing device address");
   addr_drop_a: assert property (
      st_q == ST_SWAIT && UNIT_CONNECTED && !tmo && op_en |=> !addr_q)
      else $error("address strobe not dropped on unit connect");
   cmd_after_addr_a: assert property (
      $rose(cmd_q) && st_q == ST_SCMD |-> $past(UNIT_ADDR_STROBE) && bus_q == cmdb_q)
      else $error("command strobe without returned address");
   cmd_fall_a: assert property ($fell(cmd_q) && op_en && !$past(tmo) |->
      !$past(UNIT_ADDR_STROBE) && !$past(UNIT_STATUS_STROBE))
      else $error("command strobe fell before unit tag fell");
   status_answer_a: assert property (
      st_q == ST_SCMDDN && UNIT_STATUS_STROBE && op_en && !tmo |=> ack_q != cmd_q)
      else $error("initial status not answered by exactly one tag");
   sb_addr_hold_a: assert property (
      st_q == ST_SBWAIT && op_en |-> addr_q && !sel_q)
      else $error("short busy address strobe not held");
   ack_drop_a: assert property ($fell(ack_q) && op_en && !$past(tmo) |->
      !$past(UNIT_DATA_REQUEST) || $past(st_q) == ST_SSTAT)
      else $error("data ack dropped while request high");
   bus_hold_a: assert property (ack_q && $past(ack_q) |-> $stable(bus_q))
      else $error("outbound byte changed while ack high");
   resel_go_a: assert property (
      st_q == ST_POLL && UNIT_ADDR_STROBE && UNIT_CONNECTED && op_en && !tmo
      |=> s_resel_go)
      else $error("reselection proceed not signalled");

endmodule

//--- logic/cts_parity.sv
// Odd parity generator and checker for one byte lane.
// Assumes parity is odd over data plus parity bit.
`timescale 1ns/1ps
module cts_parity
   import cts_pkg::*;
#(
   parameter int W = 8
)
(
   // Byte and its received parity bit.
   input  wire logic [W-1:0] data,
   input  wire logic         par_in,
   // Generated parity and check result.
   output logic              par_gen,
   output logic              par_ok
);

   // ======================================================
   // Odd parity: the bit makes the count of ones odd.
   always_comb
   begin
      par_gen = ~(^data);
      par_ok  = (^data) ^ par_in;
   end

endmodule

//--- logic/cts_pkg.sv
// Constants for the channel-side tag sequencer.
// Assumes one 125 MHz clock and a software port of plain strobes.
package cts_pkg;

   // ======================================================
   // Software register offsets (byte addresses).
   localparam logic [7:0] CTS_OFF_CTRL   = 8'h00;
   localparam logic [7:0] CTS_OFF_DEVADR = 8'h04;
   localparam logic [7:0] CTS_OFF_CMD    = 8'h08;
   localparam logic [7:0] CTS_OFF_START  = 8'h0C;
   localparam logic [7:0] CTS_OFF_STATUS = 8'h10;
   localparam logic [7:0] CTS_OFF_TXDATA = 8'h14;
   localparam logic [7:0] CTS_OFF_RXDATA = 8'h18;

   // ======================================================
   // Control register fields and reset value.
   localparam int CTS_CTL_OPEN  = 0;
   localparam int CTS_CTL_SUPP  = 1;
   localparam int CTS_CTL_DOUT  = 2;
   localparam int CTS_CTL_REFU  = 3;
   localparam int CTS_CTL_HOLD  = 4;
   localparam int CTS_CTL_POLL  = 5;
   localparam int CTS_CTL_W     = 6;
   localparam logic [5:0] CTS_CTL_RST = 6'h00;

   // ======================================================
   // Sticky flag positions inside the status register.
   localparam int CTS_FL_ACC  = 0;
   localparam int CTS_FL_SBSY = 1;
   localparam int CTS_FL_ERR  = 2;
   localparam int CTS_FL_TMO  = 3;
   localparam int CTS_FL_NOU  = 4;
   localparam int CTS_FL_RSEL = 5;
   localparam int CTS_FL_W    = 6;

   // ======================================================
   // Unit status byte bits and the probe command code.
   localparam int CTS_SB_ALERT = 7;
   localparam int CTS_SB_QUAL  = 6;
   localparam int CTS_SB_CFREE = 5;
   localparam int CTS_SB_BUSY  = 4;
   localparam int CTS_SB_PDONE = 3;
   localparam int CTS_SB_ECHK  = 1;
   localparam int CTS_SB_EXC   = 0;
   localparam logic [7:0] CTS_PROBE_CMD = 8'h00;

   // ======================================================
   // Watchdog on every tag wait except the idle and connected rests; the count derives from the time.
   localparam int CTS_CLK_NS   = 8;
   localparam int CTS_WDOG_NS  = 100000;
   localparam int CTS_WDOG_CYC = CTS_WDOG_NS / CTS_CLK_NS;

   // ======================================================
   // Sequencer states, Gray coded along the usual path.
   typedef enum logic [3:0] {
      ST_IDLE   = 4'h0,
      ST_SADDR  = 4'h1,
      ST_SWAIT  = 4'h3,
      ST_SADRIN = 4'h2,
      ST_SCMD   = 4'h6,
      ST_SCMDDN = 4'h7,
      ST_SSTAT  = 4'h5,
      ST_CONN   = 4'h4,
      ST_DXACK  = 4'hC,
      ST_DISC   = 4'hD,
      ST_SBWAIT = 4'hF,
      ST_POLL   = 4'hE,
      ST_RSCMD  = 4'hA
   } cts_state_t;

endpackage

//--- logic/cts_wdog.sv
// Watchdog counter for tag waits.
// Assumes kick is high in any cycle where the wait restarts.
`timescale 1ns/1ps
module cts_wdog
   import cts_pkg::*;
#(
   parameter int LIMIT = CTS_WDOG_CYC
)
(
   // Clock and reset.
   input  wire logic clk,
   input  wire logic rst,
   // Control and result.
   input  wire logic run,
   input  wire logic kick,
   output logic      expired
);

   localparam int CW = $clog2(LIMIT + 1);

   logic [CW-1:0] cnt_q;
   logic [CW-1:0] cnt_d;

   // ======================================================
   // Count while waiting; a fresh wait starts from zero.
   always_comb
   begin
      expired = run && !kick && (cnt_q == CW'(LIMIT - 1));
      if (!run || kick || expired)
         cnt_d = '0;
      else
         cnt_d = cnt_q + CW'(1);
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         cnt_q <= '0;
      else
         cnt_q <= cnt_d;
   end

endmodule
